//--- hw/bcie_kick_avg.sv
// Kick-back acquisition sequencer: repeats conversions and averages them
module bcie_kick_avg
  import bcie_pkg::*;
#(
  parameter int SUM_W = 12
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // Control
  input  wire logic              start,
  input  wire logic [1:0]        avg_sel,
  output logic                   busy,
  output logic                   done,
  output logic [CODE_W-1:0]      result,
  // Converter handshake
  input  wire bcie_adc_s         adc_in,
  output logic                   adc_start
);

  typedef enum logic {AV_IDLE, AV_WAIT} bcie_av_e;

  typedef struct packed {
    bcie_av_e          st;
    logic [3:0]        cnt;
    logic [1:0]        shift;
    logic [SUM_W-1:0]  sum;
    logic              adc_start;
    logic              done;
    logic [CODE_W-1:0] result;
  } bcie_av_s;

  bcie_av_s s_r;
  bcie_av_s s_nxt;
  logic [SUM_W-1:0] sum_add;
  logic [SUM_W-1:0] avg_val;

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.adc_start = 1'b0;
    s_nxt.done      = 1'b0;
    sum_add         = s_r.sum + SUM_W'(adc_in.data);
    avg_val         = sum_add >> s_r.shift;
    unique case (s_r.st)
      AV_IDLE:
        if (start)
        begin
          s_nxt.cnt       = 4'h0;
          s_nxt.sum       = '0;
          s_nxt.shift     = avg_sel;
          s_nxt.adc_start = 1'b1;
          s_nxt.st        = AV_WAIT;
        end
      AV_WAIT:
        if (adc_in.done)
        begin
          s_nxt.sum = sum_add;
          s_nxt.cnt = s_r.cnt + 4'h1;
          // Power-of-two counts turn the division into a shift
          if ((s_r.cnt + 4'h1) == (4'h1 << s_r.shift))
          begin
            s_nxt.result = avg_val[CODE_W-1:0];
            s_nxt.done   = 1'b1;
            s_nxt.st     = AV_IDLE;
          end
          else
          begin
            s_nxt.adc_start = 1'b1;
          end
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{st: AV_IDLE, cnt: 4'h0, shift: 2'h0, sum: '0, adc_start: 1'b0,
               done: 1'b0, result: '0};
    else if (ce)
      s_r <= s_nxt;
  end

  assign busy      = (s_r.st != AV_IDLE);
  assign done      = s_r.done;
  assign result    = s_r.result;
  assign adc_start = s_r.adc_start;

  property p_av_count_bound;
    @(posedge clk) disable iff (!reset_n)
    (s_r.st == AV_WAIT) |-> (s_r.cnt < (4'h1 << s_r.shift));
  endproperty
  a_av_count_bound: assert property (p_av_count_bound)
    else $error("averager ran past its conversion count");

  property p_av_start_conv;
    @(posedge clk) disable iff (!reset_n)
    (ce && start && s_r.st == AV_IDLE) |=> (adc_start && busy && !done);
  endproperty
  a_av_start_conv: assert property (p_av_start_conv)
    else $error("acquisition start did not launch a conversion");

endmodule

//--- hw/bcie_nvm_commit.sv
// Non-volatile commit sequencer: holds the program strobe for the write time
module bcie_nvm_commit
  import bcie_pkg::*;
#(
  parameter int NVM_COMMIT_CYCLES = NVM_NVM_COMMIT_CYCLES
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // Control
  input  wire logic              start,
  input  wire logic [CODE_W-1:0] code,
  output logic                   busy,
  output logic                   done,
  // Memory side
  output logic                   nvm_program,
  output logic [CODE_W-1:0]      nvm_word
);

  typedef enum logic {NV_IDLE, NV_NVM_COMMIT} bcie_nv_e;

  typedef struct packed {
    bcie_nv_e          st;
    logic [15:0]       cnt;
    logic              done;
    logic [CODE_W-1:0] word;
  } bcie_nv_s;

  bcie_nv_s s_r;
  bcie_nv_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      NV_IDLE:
        if (start)
        begin
          s_nxt.word = code;
          s_nxt.cnt  = 16'(NVM_COMMIT_CYCLES - 1);
          s_nxt.st   = NV_NVM_COMMIT;
        end
      NV_NVM_COMMIT:
        if (s_r.cnt == 16'h0000)
        begin
          s_nxt.done = 1'b1;
          s_nxt.st   = NV_IDLE;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{st: NV_IDLE, cnt: 16'h0000, done: 1'b0, word: '0};
    else if (ce)
      s_r <= s_nxt;
  end

  assign busy        = (s_r.st != NV_IDLE);
  assign done        = s_r.done;
  assign nvm_program = (s_r.st == NV_NVM_COMMIT);
  assign nvm_word    = s_r.word;

  property p_nv_word_held;
    @(posedge clk) disable iff (!reset_n)
    (nvm_program && $past(nvm_program)) |-> (nvm_word == $past(nvm_word));
  endproperty
  a_nv_word_held: assert property (p_nv_word_held)
    else $error("committed word changed during programming");

  property p_nv_done_after_nvm_commit;
    @(posedge clk) disable iff (!reset_n)
    done |-> (!nvm_program && $past(nvm_program));
  endproperty
  a_nv_done_after_nvm_commit: assert property (p_nv_done_after_nvm_commit)
    else $error("commit done without a programming phase");

endmodule

//--- hw/bcie_pkg.sv
// Package: register map, field layout, reset values and timing of the bias/irq bank
package bcie_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BIAS_LOW_OFS  = 8'h03;
  localparam logic [7:0] BIAS_CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQ_EN1_OFS   = 8'h05;
  localparam logic [7:0] IRQ_FLAG1_OFS = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACQ_BIT      = 7;
  localparam int COMMIT_BIT   = 6;
  localparam int FLOAT_BIT    = 5;
  localparam int AVG_LSB      = 3;
  localparam int CODE_MSB_BIT = 0;
  localparam int IRQ_ACQ_BIT  = 1;
  localparam int IRQ_NVM_COMMIT_BIT = 0;
  localparam int IRQ_EXT_LSB  = 2;
  localparam int EXT_IRQS     = 6;
  localparam int CODE_W       = 9;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] BIAS_LOW_RST    = 8'h7D;
  localparam logic [7:0] BIAS_CTRL_RST   = 8'h04;
  localparam logic [7:0] BIAS_CTRL_WMASK = 8'h3F;
  localparam logic [7:0] IRQ_EN1_RST     = 8'h7F;
  localparam logic [7:0] IRQ_EN1_WMASK   = 8'h7C;
  localparam logic [7:0] IRQ_FLAG1_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int NVM_NVM_COMMIT_TIME_US = 100;
  localparam int NVM_NVM_COMMIT_CYCLES  =
    (NVM_NVM_COMMIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcie_req_s;

  typedef struct packed {
    logic              done;
    logic [CODE_W-1:0] data;
  } bcie_adc_s;

endpackage

//--- hw/bcie_regs.sv
// Bias control and first interrupt-enable register bank with its sequencers
//
// Notes on behaviour
// - Writing one to the acquire bit starts a kick-back measurement; zero does nothing.
// - When measurement ends the acquire bit clears and the result becomes the code.
// - Writing one to the commit bit stores the code into non-volatile memory.
// - After programming the commit bit clears and the device requests standby.
// - Float bit one releases the bias pin; zero lets the amplifier drive it.
// - Averaging field selects one, two, four or eight conversions per result.
// - Conversions repeat the selected number of times and one average is returned.
// - The nine-bit code means code times minus ten millivolts at the bias output.
// - Low eight code bits sit at the preceding address; the top bit at bit zero.
// - An enabled pending interrupt pulls the active-low interrupt pin low.
// - Enable bits run temp change, shutdown, warning, hot, cold, undervoltage, acq, nvm_commit.
// - The acquisition-complete flag sets once a measurement finishes.
// - The programming-complete flag sets once the code is in non-volatile memory.
module bcie_regs
  import bcie_pkg::*;
#(
  parameter int NVM_COMMIT_CYCLES = NVM_NVM_COMMIT_CYCLES,
  parameter int SUM_W       = 12
)
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // Register port
  input  wire bcie_req_s           req,
  output logic [7:0]               reg_rdata,
  // Asynchronous event inputs, temp change at the top
  input  wire logic [EXT_IRQS-1:0] event_pins,
  // Converter handshake
  input  wire bcie_adc_s           adc_in,
  output logic                     adc_start,
  // Non-volatile memory
  output logic                     nvm_program,
  output logic [CODE_W-1:0]        nvm_word,
  // Bias output stage
  output logic [CODE_W-1:0]        bias_code,
  output logic                     bias_drive_en,
  // Mode request and interrupt pin
  output logic                     standby_req,
  output logic                     irq_pin_n_o,
  output logic                     irq_pin_n_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [EXT_IRQS-1:0] sync1;
    logic [EXT_IRQS-1:0] sync2;
    logic [7:0]          bias_low;
    logic [7:0]          bias_ctrl;
    logic [7:0]          irq_en;
    logic [7:0]          flags;
    logic [7:0]          rdata;
    logic                drive_en;
    logic                irq_oe;
    logic                standby;
  } bcie_regs_s;

  bcie_regs_s s_r;
  bcie_regs_s s_nxt;

  logic              wr_ctrl;
  logic              acq_start;
  logic              commit_start;
  logic              av_busy;
  logic              av_done;
  logic [CODE_W-1:0] av_result;
  logic              nv_busy;
  logic              nv_done;
  logic [CODE_W-1:0] cur_code;
  logic [CODE_W-1:0] commit_code;

  assign wr_ctrl  = req.wr && (req.addr == BIAS_CTRL_OFS);
  assign cur_code = {s_r.bias_ctrl[CODE_MSB_BIT], s_r.bias_low};
  // Commit stores the code as it stands after this very write, so bit 8 comes from the write
  assign commit_code = {req.wdata[CODE_MSB_BIT], s_r.bias_low};

  // Only one sequencer runs at a time; acquire wins a simultaneous request
  assign acq_start    = wr_ctrl && req.wdata[ACQ_BIT] && !av_busy && !nv_busy;
  assign commit_start = wr_ctrl && req.wdata[COMMIT_BIT] && !req.wdata[ACQ_BIT]
                        && !av_busy && !nv_busy;

  // ----------------------------------------------------------------
  // Sequencers
  // ----------------------------------------------------------------
  bcie_kick_avg #(
    .SUM_W (SUM_W)
  ) u_avg (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .start     (acq_start),
    .avg_sel   (req.wdata[AVG_LSB+1:AVG_LSB]),
    .busy      (av_busy),
    .done      (av_done),
    .result    (av_result),
    .adc_in    (adc_in),
    .adc_start (adc_start)
  );

  bcie_nvm_commit #(
    .NVM_COMMIT_CYCLES (NVM_COMMIT_CYCLES)
  ) u_nvm (
    .clk         (clk),
    .reset_n     (reset_n),
    .ce          (ce),
    .start       (commit_start),
    .code        (commit_code),
    .busy        (nv_busy),
    .done        (nv_done),
    .nvm_program (nvm_program),
    .nvm_word    (nvm_word)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.sync1   = event_pins;
    s_nxt.sync2   = s_r.sync1;
    s_nxt.standby = 1'b0;

    // Host writes
    if (req.wr)
    begin
      unique case (req.addr)
        BIAS_LOW_OFS:
          s_nxt.bias_low = req.wdata;
        BIAS_CTRL_OFS:
          s_nxt.bias_ctrl = (s_r.bias_ctrl & ~BIAS_CTRL_WMASK)
                            | (req.wdata & BIAS_CTRL_WMASK);
        IRQ_EN1_OFS:
          s_nxt.irq_en = (s_r.irq_en & ~IRQ_EN1_WMASK)
                         | (req.wdata & IRQ_EN1_WMASK);
        default:
          s_nxt.irq_en = s_r.irq_en;
      endcase
    end

    // Trigger bits read back as busy while their routine runs
    if (acq_start)
      s_nxt.bias_ctrl[ACQ_BIT] = 1'b1;
    if (commit_start)
      s_nxt.bias_ctrl[COMMIT_BIT] = 1'b1;

    // Measurement result overrides a host write to the code in the same cycle
    if (av_done)
    begin
      s_nxt.bias_ctrl[ACQ_BIT]      = 1'b0;
      s_nxt.bias_low                = av_result[7:0];
      s_nxt.bias_ctrl[CODE_MSB_BIT] = av_result[CODE_W-1];
    end
    if (nv_done)
    begin
      s_nxt.bias_ctrl[COMMIT_BIT] = 1'b0;
      s_nxt.standby               = 1'b1;
    end

    // Flags clear on read, but a set in the same cycle wins
    if (req.rd && (req.addr == IRQ_FLAG1_OFS))
      s_nxt.flags = IRQ_FLAG1_RST;
    s_nxt.flags[7:IRQ_EXT_LSB] = s_nxt.flags[7:IRQ_EXT_LSB] | s_r.sync2;
    if (av_done)
      s_nxt.flags[IRQ_ACQ_BIT] = 1'b1;
    if (nv_done)
      s_nxt.flags[IRQ_NVM_COMMIT_BIT] = 1'b1;

    // Outputs, one cycle behind the state that drives them
    s_nxt.drive_en = !s_r.bias_ctrl[FLOAT_BIT];
    s_nxt.irq_oe   = |(s_r.flags & s_r.irq_en);

    // Read answer on the next edge
    if (req.rd)
    begin
      unique case (req.addr)
        BIAS_LOW_OFS:  s_nxt.rdata = s_r.bias_low;
        BIAS_CTRL_OFS: s_nxt.rdata = s_r.bias_ctrl;
        IRQ_EN1_OFS:   s_nxt.rdata = s_r.irq_en;
        IRQ_FLAG1_OFS: s_nxt.rdata = s_r.flags;
        default:       s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '{sync1: '0, sync2: '0, bias_low: BIAS_LOW_RST, bias_ctrl: BIAS_CTRL_RST,
               irq_en: IRQ_EN1_RST, flags: IRQ_FLAG1_RST, rdata: 8'h00,
               drive_en: 1'b1, irq_oe: 1'b0, standby: 1'b0};
    else if (ce)
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bias stage turns code into code x -10 mV; the code leaves unchanged
  assign bias_code     = cur_code;
  assign bias_drive_en = s_r.drive_en;
  assign reg_rdata     = s_r.rdata;
  assign standby_req   = s_r.standby;
  // Open drain: only ever pulls low
  assign irq_pin_n_o   = 1'b0;
  assign irq_pin_n_oe  = s_r.irq_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_acq_starts;
    @(posedge clk) disable iff (!reset_n)
    (ce && wr_ctrl && req.wdata[ACQ_BIT] && !av_busy && !nv_busy)
      |=> (s_r.bias_ctrl[ACQ_BIT] && av_busy);
  endproperty
  a_acq_starts: assert property (p_acq_starts)
    else $error("acquire write did not start a measurement");

  property p_acq_result;
    @(posedge clk) disable iff (!reset_n)
    (ce && av_done) |=> (!s_r.bias_ctrl[ACQ_BIT] && bias_code == $past(av_result));
  endproperty
  a_acq_result: assert property (p_acq_result)
    else $error("measurement end did not clear acquire or load the code");

  property p_commit_starts;
    @(posedge clk) disable iff (!reset_n)
    (ce && commit_start) |=> (nvm_program && nvm_word == bias_code);
  endproperty
  a_commit_starts: assert property (p_commit_starts)
    else $error("commit write did not program the current code");

  property p_commit_ends;
    @(posedge clk) disable iff (!reset_n)
    (ce && nv_done) |=> (!s_r.bias_ctrl[COMMIT_BIT] && standby_req);
  endproperty
  a_commit_ends: assert property (p_commit_ends)
    else $error("programming end did not clear commit or request standby");

  property p_float_pin;
    @(posedge clk) disable iff (!reset_n)
    (ce && $past(ce)) |-> (bias_drive_en == !$past(s_r.bias_ctrl[FLOAT_BIT]));
  endproperty
  a_float_pin: assert property (p_float_pin)
    else $error("bias pin drive does not follow the float bit");

  property p_low_byte_read;
    @(posedge clk) disable iff (!reset_n)
    (ce && req.rd && req.addr == BIAS_LOW_OFS) |=> (reg_rdata == $past(s_r.bias_low));
  endproperty
  a_low_byte_read: assert property (p_low_byte_read)
    else $error("low code byte read back wrong");

  property p_irq_pin;
    @(posedge clk) disable iff (!reset_n)
    (ce && $past(ce)) |-> (irq_pin_n_oe == |($past(s_r.flags) & $past(s_r.irq_en)));
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin does not follow enabled flags");

  property p_enable_ro_bits;
    @(posedge clk) disable iff (!reset_n)
    (ce && req.wr && req.addr == IRQ_EN1_OFS)
      |=> (s_r.irq_en[7] == $past(s_r.irq_en[7]) && s_r.irq_en[1:0] == $past(s_r.irq_en[1:0]));
  endproperty
  a_enable_ro_bits: assert property (p_enable_ro_bits)
    else $error("read-only enable bits changed on write");

  property p_acq_flag;
    @(posedge clk) disable iff (!reset_n)
    (ce && av_done) |=> s_r.flags[IRQ_ACQ_BIT];
  endproperty
  a_acq_flag: assert property (p_acq_flag)
    else $error("acquisition flag not set after measurement");

  property p_nvm_commit_flag;
    @(posedge clk) disable iff (!reset_n)
    (ce && nv_done) |=> s_r.flags[IRQ_NVM_COMMIT_BIT];
  endproperty
  a_nvm_commit_flag: assert property (p_nvm_commit_flag)
    else $error("programming flag not set after commit");

endmodule

//--- tb/bcie_adc_model.sv
// Converter model that answers each conversion request after a chosen lag
module bcie_adc_model
  import bcie_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Conversion handshake
  input  wire logic       adc_start,
  input  wire logic [8:0] base,
  input  wire logic [1:0] lag,
  output bcie_adc_s       adc_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] k    = 9'h000;
  logic [8:0] last = 9'h000;
  int         cnt  = -1;

  initial adc_o = '0;

  // Data is only valid with done; between answers the line shows the inverse of the last
  // result, so a design that samples it late cannot see a stale match
  always @(negedge clk)
  begin
    if (cnt == 0)
    begin
      adc_o.done <= 1'b1;
      adc_o.data <= base + k;
      last = base + k;
      k = k + 9'h001;
    end
    else
    begin
      adc_o.done <= 1'b0;
      adc_o.data <= ~last;
    end
    if (adc_start === 1'b1)
      cnt = lag;
    else if (cnt >= 0)
      cnt = cnt - 1;
  end
endmodule

//--- tb/bias_calibration_irq_enable_regs_bench.sv
// Self-checking bench for the bias control and interrupt-enable register bank
module bias_calibration_irq_enable_regs_bench
  import bcie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Short programming time keeps the run brief
  localparam int NVM_COMMIT = 4;
  logic       clk         = 1'b0;
  logic       reset_n     = 1'b0;
  logic       ce          = 1'b1;
  bcie_req_s  req         = '0;
  logic [5:0] event_pins  = 6'h00;
  logic [8:0] smp_base    = 9'h000;
  logic [1:0] lag         = 2'h0;
  logic [8:0] word_seen   = 9'h000;
  bcie_adc_s  adc_in;
  logic       adc_start;
  logic       nvm_program;
  logic       drive_en;
  logic       standby_req;
  logic       irq_o;
  logic       irq_oe;
  logic [8:0] nvm_word;
  logic [8:0] bias_code;
  logic [7:0] reg_rdata;
  int         err_total   = 0;
  int         comparisons = 0;
  int         seed        = 78350;
  int         starts      = 0;
  int         nvm_commit_cyc    = 0;
  int         stby        = 0;

  always #50 clk = ~clk;

  bcie_regs #(.NVM_COMMIT_CYCLES(NVM_COMMIT), .SUM_W(12)) bcie_regs_inst (
    .clk(clk), .reset_n(reset_n), .ce(ce), .req(req), .reg_rdata(reg_rdata),
    .event_pins(event_pins), .adc_in(adc_in), .adc_start(adc_start),
    .nvm_program(nvm_program), .nvm_word(nvm_word), .bias_code(bias_code),
    .bias_drive_en(drive_en), .standby_req(standby_req), .irq_pin_n_o(irq_o),
    .irq_pin_n_oe(irq_oe));

  bcie_adc_model bcie_adc_model_inst (
    .clk(clk), .adc_start(adc_start), .base(smp_base), .lag(lag), .adc_o(adc_in));

  always @(posedge clk)
  begin
    if (adc_start === 1'b1)
      starts <= starts + 1;
    if (nvm_program === 1'b1)
      nvm_commit_cyc <= nvm_commit_cyc + 1;
    if (nvm_program === 1'b1)
      word_seen <= nvm_word;
    if (standby_req === 1'b1)
      stby <= stby + 1;
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [8:0] avg_of(input logic [8:0] b, input logic [8:0] k0,
                                        input int a);
    logic [11:0] s;
    s = '0;
    for (int i = 0; i < (1 << a); i++)
      s = s + 12'(9'(b + k0 + 9'(i)));
    return 9'(s >> a);
  endfunction

  task automatic conclude();
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
    d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    comparisons++;
    if (d !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: reg %h read %h expected %h", $time, a, d, e);
    end
  endtask

  task automatic chk_val(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: port value %h expected %h", $time, g, e);
    end
  endtask

  // Polls the control register; a bit that never clears counts as a mismatch
  task automatic wait_clear(input int bitn);
    logic [7:0] d;
    int         n;
    n = 0;
    d = 8'hFF;
    while (d[bitn] !== 1'b0 && n < 200)
    begin
      rd(BIAS_CTRL_OFS, d);
      n++;
    end
    chk_val(9'(n == 200), 9'h000);
  endtask

  initial
  begin
    #(100 * 40000);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] lo;
    logic [7:0] d;
    logic [8:0] k0;
    logic [8:0] ex;
    int         s0;
    int         p0;
    repeat (4) @(negedge clk);
    reset_n <= 1'b1;
    chk_reg(BIAS_LOW_OFS, BIAS_LOW_RST);
    chk_reg(BIAS_CTRL_OFS, BIAS_CTRL_RST);
    chk_reg(IRQ_EN1_OFS, IRQ_EN1_RST);
    chk_reg(IRQ_FLAG1_OFS, IRQ_FLAG1_RST);
    chk_reg(8'h00, 8'h00);
    chk_val(bias_code, 9'h07D);
    chk_val(9'(drive_en), 9'h001);
    chk_val(9'(irq_o), 9'h000);
    for (int i = 0; i < 8; i++)
    begin
      lo = 8'($random(seed));
      d = 8'($random(seed)) & BIAS_CTRL_WMASK;
      wr(BIAS_LOW_OFS, lo);
      wr(BIAS_CTRL_OFS, d);
      chk_reg(BIAS_CTRL_OFS, d);
      chk_val(bias_code, {d[CODE_MSB_BIT], lo});
      chk_val(9'(drive_en), 9'(!d[FLOAT_BIT]));
      wr(IRQ_EN1_OFS, lo);
      chk_reg(IRQ_EN1_OFS, (lo & IRQ_EN1_WMASK) | (IRQ_EN1_RST & ~IRQ_EN1_WMASK));
    end
    chk_val(9'(starts + nvm_commit_cyc), 9'h000);
    for (int a = 0; a < 4; a++)
    begin
      lag <= 2'($random(seed));
      smp_base <= 9'($random(seed));
      wr(BIAS_CTRL_OFS, 8'h20);
      k0 = bcie_adc_model_inst.k;
      s0 = starts;
      p0 = nvm_commit_cyc;
      // Commit requested together with acquire must be ignored
      wr(BIAS_CTRL_OFS, 8'hE0 | 8'(a << AVG_LSB));
      chk_val(9'(drive_en), 9'h000);
      wait_clear(ACQ_BIT);
      ex = avg_of(smp_base, k0, a);
      chk_val(9'(starts - s0), 9'(1 << a));
      chk_val(bias_code, ex);
      chk_val(9'(nvm_commit_cyc - p0), 9'h000);
      chk_reg(BIAS_CTRL_OFS, 8'h20 | 8'(a << AVG_LSB) | 8'(ex[8]));
      chk_val(9'(irq_oe), 9'h001);
      chk_reg(IRQ_FLAG1_OFS, 8'h02);
      @(negedge clk);
      chk_val(9'(irq_oe), 9'h000);
    end
    lo = 8'($random(seed));
    wr(BIAS_LOW_OFS, lo);
    wr(BIAS_CTRL_OFS, 8'h41);
    wait_clear(COMMIT_BIT);
    chk_val(9'(nvm_commit_cyc), 9'(NVM_COMMIT));
    chk_val(word_seen, {1'b1, lo});
    chk_val(9'(stby), 9'h001);
    chk_reg(IRQ_FLAG1_OFS, 8'h01);
    // Clock enable low: a write presented only while frozen must not land
    @(negedge clk);
    ce  <= 1'b0;
    req <= '{wr: 1'b1, rd: 1'b0, addr: BIAS_LOW_OFS, wdata: ~lo};
    repeat (3) @(negedge clk);
    req <= '0;
    @(negedge clk);
    ce  <= 1'b1;
    chk_reg(BIAS_LOW_OFS, lo);
    for (int i = 0; i < EXT_IRQS; i++)
    begin
      wr(IRQ_EN1_OFS, 8'(1 << (i + IRQ_EXT_LSB)));
      event_pins[i] <= 1'b1;
      repeat (5) @(negedge clk);
      // The temperature-change enable is read-only zero, so that source never reaches the pin
      chk_val(9'(irq_oe), 9'(IRQ_EN1_WMASK[i + IRQ_EXT_LSB]));
      event_pins[i] <= 1'b0;
      repeat (4) @(negedge clk);
      chk_reg(IRQ_FLAG1_OFS, 8'(1 << (i + IRQ_EXT_LSB)));
      @(negedge clk);
      chk_val(9'(irq_oe), 9'h000);
      wr(IRQ_EN1_OFS, 8'h00);
      event_pins[i] <= 1'b1;
      repeat (5) @(negedge clk);
      chk_val(9'(irq_oe), 9'h000);
      event_pins[i] <= 1'b0;
      repeat (4) @(negedge clk);
      chk_reg(IRQ_FLAG1_OFS, 8'(1 << (i + IRQ_EXT_LSB)));
    end
    conclude();
  end
endmodule
